// ### verilog/asc_seq0_ctl.sv
//----------------------------------------------------------------------
// Purpose : sequence 0 sample control with step sequencer, result
//           queue and interrupt gating behind an AXI4-Lite slave
// Assumes : converter handshake runs on clk_sys
// Notes   : Summary of operation
// Summary of operation
// RQ1 - eight four-bit slots: temp select, irq enable, last flag, diff
// RQ2 - temp select set converts sensor, else the selected external input
// RQ3 - irq enable set raises raw interrupt when that sample completes
// RQ4 - raw interrupt reaches controller output only while unmasked
// RQ5 - several slots in one sequence may each raise the raw interrupt
// RQ6 - slot with last flag ends the sequence, any position allowed
// RQ7 - slots after the first last flag are never requested
// RQ8 - software sets a last flag somewhere before running a sequence
// RQ9 - single-sample sequencer has its last flag fixed at one
// RQ10 - diff select reads input field as pair i, inputs 2i and 2i+1
// RQ11 - temperature sensor has no differential mode
// RQ12 - per-slot input field gives the external input number
// RQ13 - results queue and read back in slot order from slot zero
// RQ14 - trigger steps slots upward from zero, stops after last slot
//----------------------------------------------------------------------
`include "asc_cfg.svh"

module asc_seq0_ctl
  import asc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             convReq,
  output logic             convTempSel,
  output logic             convDiffSel,
  output logic [3:0]       convChanP,
  output logic [3:0]       convChanN,
  input  wire logic        convDone,
  input  wire logic [9:0]  convResult,
  output logic             ctrlIrq
);

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  // one slot nibble out of a packed word
  function automatic logic [3:0] nibble(input logic [31:0] w,
                                        input logic [2:0]  i);
    nibble = w[{i, 2'b00} +: 4]; // RQ1
  endfunction

  // byte-lane merge for strobed writes
  function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
    begin
      if (s[k])
        r[8*k +: 8] = d[8*k +: 8];
    end
    applyStrb = r;
  endfunction

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  asc_state_type st_r;
  asc_state_type st_nxt;
  logic [3:0]    curFlags;
  logic [3:0]    curInput;

  // flags and input field of the slot being worked on
  assign curFlags = nibble(st_r.ctl0, st_r.slot);
  assign curInput = nibble(st_r.mux0, st_r.slot);

  //--------------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------------
  // bus first, sequencer after, so hardware sets beat software clears
  always_comb
  begin
    logic doWr;
    logic doRd;
    logic startRun;
    logic push;
    logic pushOk;
    logic pop;
    doWr     = 1'b0;
    doRd     = 1'b0;
    startRun = 1'b0;
    push     = 1'b0;
    pushOk   = 1'b0;
    pop      = 1'b0;
    st_nxt   = st_r;
    st_nxt.convReq = 1'b0;

    // write channel capture, either order
    if (s_axi_awvalid && st_r.awRdy)
    begin
      st_nxt.awFull = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wRdy)
    begin
      st_nxt.wFull = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready)
      st_nxt.bValid = 1'b0;

    // register write once both halves are held
    doWr = st_r.awFull && st_r.wFull && !st_r.bValid;
    if (doWr)
    begin
      st_nxt.awFull = 1'b0;
      st_nxt.wFull  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = `ASC_RESP_OKAY;
      case (st_r.awAddr)
        `ASC_OFF_RAWSTAT:
        begin
          // write one to clear
          if (st_r.wStrb[0] && st_r.wData[0])
            st_nxt.raw = 1'b0;
        end
        `ASC_OFF_MASK:
          if (st_r.wStrb[0])
            st_nxt.mask = st_r.wData[0];
        `ASC_OFF_RUN:
          startRun = st_r.wStrb[0] && st_r.wData[0];
        `ASC_OFF_MUX0:
          st_nxt.mux0 = applyStrb(st_r.mux0, st_r.wData, st_r.wStrb);
        `ASC_OFF_CTL0:
          st_nxt.ctl0 = applyStrb(st_r.ctl0, st_r.wData, st_r.wStrb); // RQ1
        `ASC_OFF_CTL3:
        begin
          // last flag of the single slot cannot be cleared
          if (st_r.wStrb[0])
            st_nxt.ctl3 = {st_r.wData[3:2], 1'b1, st_r.wData[0]}; // RQ9
        end
        `ASC_OFF_FIFO0,
        `ASC_OFF_FSTAT0:
          st_nxt.bResp = `ASC_RESP_OKAY;
        default:
          st_nxt.bResp = `ASC_RESP_SLVERR;
      endcase
    end

    // read channel, answer in the next cycle
    if (st_r.rValid && s_axi_rready)
      st_nxt.rValid = 1'b0;
    doRd = s_axi_arvalid && st_r.arRdy;
    if (doRd)
    begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = `ASC_RESP_OKAY;
      st_nxt.rData  = 32'h0000_0000;
      case (s_axi_araddr)
        `ASC_OFF_RAWSTAT:
          st_nxt.rData[0] = st_r.raw;
        `ASC_OFF_MASK:
          st_nxt.rData[0] = st_r.mask;
        `ASC_OFF_RUN:
          st_nxt.rData[0] = (st_r.seq != ASC_IDLE);
        `ASC_OFF_MUX0:
          st_nxt.rData = st_r.mux0;
        `ASC_OFF_CTL0:
          st_nxt.rData = st_r.ctl0;
        `ASC_OFF_CTL3:
          st_nxt.rData[3:0] = st_r.ctl3;
        `ASC_OFF_FIFO0:
        begin
          // empty queue reads zero and does not move the tail
          if (st_r.count != 4'h0)
          begin
            st_nxt.rData[9:0] = st_r.fifo[st_r.tail]; // RQ13
            pop = 1'b1;
          end
        end
        `ASC_OFF_FSTAT0:
        begin
          st_nxt.rData[12]  = (st_r.count == `ASC_FIFO_DEPTH);
          st_nxt.rData[8]   = (st_r.count == 4'h0);
          st_nxt.rData[7:4] = {1'b0, st_r.head};
          st_nxt.rData[3:0] = {1'b0, st_r.tail};
        end
        default:
          st_nxt.rResp = `ASC_RESP_SLVERR;
      endcase
    end

    // sequencer; a run request while busy is ignored
    unique case (st_r.seq)
      ASC_IDLE:
      begin
        if (startRun)
        begin
          st_nxt.slot = 3'h0; // RQ14
          st_nxt.seq  = ASC_REQ;
        end
      end
      ASC_REQ:
      begin
        st_nxt.convReq  = 1'b1;
        st_nxt.convTemp = curFlags[`ASC_BIT_TSEL]; // RQ2
        // sensor has no pair mode, so diff is dropped with it
        st_nxt.convDiff = curFlags[`ASC_BIT_DIFF] &&
                          !curFlags[`ASC_BIT_TSEL]; // RQ11
        if (st_nxt.convDiff)
        begin
          st_nxt.chanP = {curInput[2:0], 1'b0}; // RQ10
          st_nxt.chanN = {curInput[2:0], 1'b1}; // RQ10
        end
        else
        begin
          st_nxt.chanP = curInput; // RQ12
          st_nxt.chanN = curInput;
        end
        st_nxt.seq = ASC_WAIT;
      end
      ASC_WAIT:
      begin
        if (convDone)
        begin
          push = 1'b1;
          if (curFlags[`ASC_BIT_IE])
            st_nxt.raw = 1'b1; // RQ3 RQ5
          // without any last flag the run ends at slot seven
          if (curFlags[`ASC_BIT_END] || st_r.slot == `ASC_LAST_SLOT)
            st_nxt.seq = ASC_IDLE; // RQ6 RQ7 RQ8
          else
          begin
            st_nxt.slot = st_r.slot + 3'h1; // RQ14
            st_nxt.seq  = ASC_REQ;
          end
        end
      end
    endcase

    // result queue; a full queue drops the new result
    pushOk = push && (st_r.count != `ASC_FIFO_DEPTH);
    if (pushOk)
    begin
      st_nxt.fifo[st_r.head] = convResult; // RQ13
      st_nxt.head = st_r.head + 3'h1;
    end
    if (pop)
      st_nxt.tail = st_r.tail + 3'h1;
    if (pushOk && !pop)
      st_nxt.count = st_r.count + 4'h1;
    else if (!pushOk && pop)
      st_nxt.count = st_r.count - 4'h1;

    // gated interrupt and registered ready flags
    st_nxt.irq   = st_nxt.raw && st_nxt.mask; // RQ4
    st_nxt.awRdy = !st_nxt.awFull && !st_nxt.bValid;
    st_nxt.wRdy  = !st_nxt.wFull && !st_nxt.bValid;
    st_nxt.arRdy = !st_nxt.rValid;
  end

  //--------------------------------------------------------------------
  // state register
  //--------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r      <= '0;
      st_r.ctl0 <= `ASC_RST_CTL0;
      st_r.mux0 <= `ASC_RST_MUX0;
      st_r.ctl3 <= `ASC_RST_CTL3; // RQ9
    end
    else
      st_r <= st_nxt;
  end

  //--------------------------------------------------------------------
  // outputs, all straight from the state register
  //--------------------------------------------------------------------
  assign s_axi_awready = st_r.awRdy;
  assign s_axi_wready  = st_r.wRdy;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_arready = st_r.arRdy;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign s_axi_rvalid  = st_r.rValid;
  assign convReq       = st_r.convReq;
  assign convTempSel   = st_r.convTemp;
  assign convDiffSel   = st_r.convDiff;
  assign convChanP     = st_r.chanP;
  assign convChanN     = st_r.chanN;
  assign ctrlIrq       = st_r.irq;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // a finished sample whose slot carries the last flag
  sequence seqDoneLast;
    st_r.seq == ASC_WAIT && convDone && curFlags[`ASC_BIT_END];
  endsequence
  // sequencer back to rest with no further request
  sequence seqBackIdle;
    st_r.seq == ASC_IDLE && !convReq ##1 !convReq;
  endsequence

  chk_end_stops: assert property (seqDoneLast |=> seqBackIdle) // RQ7
    else $error("request issued after last slot");
  chk_end_any_slot: assert property (seqDoneLast |=> // RQ6
                                     st_r.seq == ASC_IDLE)
    else $error("last flag did not end the sequence");
  chk_raw_on_ie: assert property (st_r.seq == ASC_WAIT && convDone && // RQ5
                                  curFlags[`ASC_BIT_IE] |=> st_r.raw)
    else $error("raw interrupt missed after sample");
  chk_raw_cause: assert property ($rose(st_r.raw) |-> // RQ3
    $past(convDone && curFlags[`ASC_BIT_IE] && st_r.seq == ASC_WAIT))
    else $error("raw interrupt without enabled sample");
  chk_irq_gate: assert property (ctrlIrq == (st_r.raw && st_r.mask)) // RQ4
    else $error("controller interrupt does not follow raw and mask");
  // a conversion may end right after its request, so no wait is demanded
  chk_req_pulse: assert property (convReq |-> st_r.seq == ASC_WAIT ##1 // RQ14
                                  !convReq)
    else $error("request not a single pulse");
  chk_start_slot0: assert property (st_r.seq == ASC_IDLE ##1 // RQ14
    st_r.seq == ASC_REQ |-> st_r.slot == 3'h0)
    else $error("sequence did not start at slot zero");
  chk_temp_source: assert property (convReq |-> convTempSel == // RQ2
                                    $past(curFlags[`ASC_BIT_TSEL]))
    else $error("wrong source for sample");
  chk_temp_nodiff: assert property (convTempSel |-> !convDiffSel) // RQ11
    else $error("differential with temperature sensor");
  chk_pair_chan: assert property (convReq && convDiffSel |-> // RQ10
    !convChanP[0] && convChanN == convChanP + 4'h1 &&
    convChanP[3:1] == $past(curInput[2:0]))
    else $error("wrong differential pair");
  chk_input_sel: assert property (convReq && !convDiffSel |-> // RQ12
                                  convChanP == $past(curInput))
    else $error("wrong input for sample");
  chk_end_fixed: assert property (st_r.ctl3[1] ##1 st_r.ctl3[1]) // RQ9
    else $error("single slot last flag cleared");
  chk_fifo_push: assert property (st_r.seq == ASC_WAIT && convDone && // RQ13
    st_r.count != `ASC_FIFO_DEPTH |=> st_r.head == $past(st_r.head) + 3'h1)
    else $error("result not queued");

endmodule // asc_seq0_ctl

// ### verilog/asc_cfg.svh
//----------------------------------------------------------------------
// Purpose : constants for the sequence 0 sample control block
// Assumes : 12-bit byte address on the register bus
// Notes   : offsets, field positions, last slot, queue depth, reset values and responses only
//----------------------------------------------------------------------
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

//----------------------------------------------------------------------
// register byte offsets
//----------------------------------------------------------------------
`define ASC_OFF_RAWSTAT  12'h004
`define ASC_OFF_MASK     12'h008
`define ASC_OFF_RUN      12'h028
`define ASC_OFF_MUX0     12'h040
`define ASC_OFF_CTL0     12'h044
`define ASC_OFF_FIFO0    12'h048
`define ASC_OFF_FSTAT0   12'h04C
`define ASC_OFF_CTL3     12'h0A4

//----------------------------------------------------------------------
// field positions inside one four-bit slot, last slot number and queue depth
//----------------------------------------------------------------------
`define ASC_BIT_TSEL     3
`define ASC_BIT_IE       2
`define ASC_BIT_END      1
`define ASC_BIT_DIFF     0
`define ASC_LAST_SLOT    3'h7
`define ASC_FIFO_DEPTH   4'h8

//----------------------------------------------------------------------
// reset values and responses
//----------------------------------------------------------------------
`define ASC_RST_CTL0     32'h0000_0000
`define ASC_RST_MUX0     32'h0000_0000
`define ASC_RST_CTL3     4'h2
`define ASC_RESP_OKAY    2'h0
`define ASC_RESP_SLVERR  2'h2

`endif

// ### verilog/asc_pkg.sv
//----------------------------------------------------------------------
// Purpose : types for the sequence 0 sample control block
// Assumes : nothing beyond the constants header
// Notes   : whole block state lives in one packed struct
//----------------------------------------------------------------------
package asc_pkg;

  //--------------------------------------------------------------------
  // sequencer states
  //--------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ASC_IDLE = 2'b00,
    ASC_REQ  = 2'b01,
    ASC_WAIT = 2'b10
  } asc_seq_type;

  //--------------------------------------------------------------------
  // complete block state
  //--------------------------------------------------------------------
  typedef struct packed
  {
    asc_seq_type      seq;
    logic [2:0]       slot;
    logic [31:0]      ctl0;
    logic [31:0]      mux0;
    logic [3:0]       ctl3;
    logic             mask;
    logic             raw;
    logic             irq;
    logic             convReq;
    logic             convTemp;
    logic             convDiff;
    logic [3:0]       chanP;
    logic [3:0]       chanN;
    logic [7:0][9:0]  fifo;
    logic [2:0]       head;
    logic [2:0]       tail;
    logic [3:0]       count;
    logic             awRdy;
    logic             wRdy;
    logic             awFull;
    logic             wFull;
    logic [11:0]      awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bValid;
    logic [1:0]       bResp;
    logic             arRdy;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
  } asc_state_type;

endpackage

// ### tb/tb_adc_sequence0_sample_control.sv
//----------------------------------------
// Purpose : self-checking bench, sequence 0 sample control
// Assumes : bench answers the converter handshake on clk_sys
// Notes   : one task per scenario, watchdog cuts a hang short
//----------------------------------------
`include "asc_cfg.svh"

module tb_adc_sequence0_sample_control;
  timeunit 1ns;
  timeprecision 100ps;

  //----------------------------------------
  // signals and device
  //----------------------------------------
  logic        clk_sys, reset;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, convChanP, convChanN;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, convReq, convTempSel;
  logic        convDiffSel, convDone, ctrlIrq;
  logic [9:0]  convResult;
  int          cycles = 0;
  int          reqCount = 0;
  int          served = 0;
  int          nMismatch = 0;
  int          totalChecks = 0;

  asc_seq0_ctl asc_seq0_ctl_i
  (
    .clk_sys, .reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convReq, .convTempSel, .convDiffSel, .convChanP, .convChanN,
    .convDone, .convResult, .ctrlIrq
  );

  // clock at 25 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // request pulses are counted so a pulse during a bus cycle is not lost
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (convReq === 1'b1)
      reqCount <= reqCount + 1;
    if (cycles == 20000)
    begin
      nMismatch++;
      printVerdict();
    end
  end

  //----------------------------------------
  // shared tasks
  //----------------------------------------
  task automatic printVerdict();
    $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // register words and bus responses
  task automatic compareReg(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // converter selects and the controller interrupt pin
  task automatic comparePin(input logic [9:0] got, input logic [9:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    logic awTaken;
    logic wTaken;
    awTaken = 1'b0;
    wTaken = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awTaken && wTaken))
    begin
      @(posedge clk_sys);
      if (!awTaken && s_axi_awready === 1'b1)
      begin
        awTaken = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wTaken && s_axi_wready === 1'b1)
      begin
        wTaken = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    compareReg({30'h0, s_axi_bresp}, {30'h0, `ASC_RESP_OKAY});
    // one idle edge so a following call never re-raises bready in this step
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // one idle edge so a following call never re-raises rready in this step
    @(posedge clk_sys);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    compareReg(d, exp);
  endtask

  // poll the busy flag; the watchdog bounds the wait
  task automatic waitIdle();
    logic [31:0] d;
    logic [1:0]  r;
    do rd(`ASC_OFF_RUN, d, r); while (d[0] !== 1'b0);
  endtask

  // answer one conversion request; channels mean nothing for the sensor
  task automatic serve(input logic t, input logic df, input logic [3:0] p,
                       input logic [3:0] n, input logic [9:0] res);
    while (reqCount == served)
      @(posedge clk_sys);
    served++;
    comparePin({8'h00, convTempSel, convDiffSel}, {8'h00, t, df});
    if (!t)
      comparePin({2'h0, convChanP, convChanN}, {2'h0, p, n});
    convDone <= 1'b1;
    convResult <= res;
    @(posedge clk_sys);
    convDone <= 1'b0;
    convResult <= ~res;
  endtask

  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic testReset();
    logic [31:0] d;
    logic [1:0]  r;
    rdChk(`ASC_OFF_CTL0, `ASC_RST_CTL0);
    rdChk(`ASC_OFF_MUX0, `ASC_RST_MUX0);
    rdChk(`ASC_OFF_FSTAT0, 32'h0000_0100);
    rdChk(`ASC_OFF_CTL3, 32'h0000_0002);
    wr(`ASC_OFF_CTL3, 32'h0000_0000);
    rdChk(`ASC_OFF_CTL3, 32'h0000_0002);
    wr(`ASC_OFF_CTL0, 32'hFFFF_FFFF);
    rdChk(`ASC_OFF_CTL0, 32'hFFFF_FFFF);
    wr(`ASC_OFF_CTL0, 32'h5A5A_A5A5);
    rdChk(`ASC_OFF_CTL0, 32'h5A5A_A5A5);
    // byte lanes 0 and 2 only
    wr(`ASC_OFF_CTL0, 32'h1234_5678, 4'h5);
    rdChk(`ASC_OFF_CTL0, 32'h5A34_A578);
    rd(12'h3F0, d, r);
    compareReg({30'h0, r}, {30'h0, `ASC_RESP_SLVERR});
    compareReg(d, 32'h0000_0000);
  endtask

  // plain, sensor with diff, pair, irq-last, then a filled slot never run
  task automatic testRun();
    int base;
    base = reqCount;
    wr(`ASC_OFF_MASK, 32'h0000_0000);
    wr(`ASC_OFF_MUX0, 32'h0002_9305);
    wr(`ASC_OFF_CTL0, 32'h000F_61D0);
    wr(`ASC_OFF_RUN, 32'h0000_0001);
    rdChk(`ASC_OFF_RUN, 32'h0000_0001);
    serve(1'b0, 1'b0, 4'h5, 4'h5, 10'h101);
    rdChk(`ASC_OFF_RAWSTAT, 32'h0000_0000);
    serve(1'b1, 1'b0, 4'h0, 4'h0, 10'h202);
    rdChk(`ASC_OFF_RAWSTAT, 32'h0000_0001);
    comparePin({9'h000, ctrlIrq}, 10'h000);
    wr(`ASC_OFF_MASK, 32'h0000_0001);
    comparePin({9'h000, ctrlIrq}, 10'h001);
    wr(`ASC_OFF_RAWSTAT, 32'h0000_0001);
    comparePin({9'h000, ctrlIrq}, 10'h000);
    serve(1'b0, 1'b1, 4'h6, 4'h7, 10'h303);
    serve(1'b0, 1'b0, 4'h9, 4'h9, 10'h3FF);
    waitIdle();
    rdChk(`ASC_OFF_RAWSTAT, 32'h0000_0001);
    comparePin({9'h000, ctrlIrq}, 10'h001);
    compareReg(reqCount - base, 32'h0000_0004);
    rdChk(`ASC_OFF_FIFO0, 32'h0000_0101);
    rdChk(`ASC_OFF_FIFO0, 32'h0000_0202);
    rdChk(`ASC_OFF_FIFO0, 32'h0000_0303);
    rdChk(`ASC_OFF_FIFO0, 32'h0000_03FF);
    rdChk(`ASC_OFF_FSTAT0, 32'h0000_0144);
    wr(`ASC_OFF_RAWSTAT, 32'h0000_0001);
    wr(`ASC_OFF_MASK, 32'h0000_0000);
  endtask

  // last flag on the first slot, then on the eighth, filling the queue
  task automatic testEnd();
    int          base;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`ASC_OFF_MUX0, 32'h7654_3210);
    wr(`ASC_OFF_CTL0, 32'hFFFF_FFF2);
    base = reqCount;
    wr(`ASC_OFF_RUN, 32'h0000_0001);
    serve(1'b0, 1'b0, 4'h0, 4'h0, 10'h0AA);
    waitIdle();
    compareReg(reqCount - base, 32'h0000_0001);
    rdChk(`ASC_OFF_FIFO0, 32'h0000_00AA);
    wr(`ASC_OFF_CTL0, 32'h2000_0000);
    base = reqCount;
    wr(`ASC_OFF_RUN, 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      serve(1'b0, 1'b0, 4'(i), 4'(i), 10'h040 + 10'(i));
    waitIdle();
    compareReg(reqCount - base, 32'h0000_0008);
    rdChk(`ASC_OFF_RAWSTAT, 32'h0000_0000);
    rd(`ASC_OFF_FSTAT0, d, r);
    compareReg({30'h0, d[12], d[8]}, 32'h0000_0002);
    for (int i = 0; i < 8; i++)
      rdChk(`ASC_OFF_FIFO0, 32'h0000_0040 + 32'(i));
    rd(`ASC_OFF_FSTAT0, d, r);
    compareReg({30'h0, d[12], d[8]}, 32'h0000_0001);
  endtask

  // inputs set at time zero, reset held for 16 cycles
  initial
  begin
    reset = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    convDone = 1'b0;
    convResult = 10'h000;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    testReset();
    testRun();
    testEnd();
    printVerdict();
  end

endmodule // tb_adc_sequence0_sample_control
